// >>> mcw_pkg.sv
/*
 * mcw_pkg: constants for the mode code control word logic.
 * Assumes a 32-bit APB slave; each register takes one aligned word.
 */
package mcw_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_RX_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_TX_CTRL  = 8'h04;
  localparam logic [7:0] ADDR_CONFIG   = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  // control word fields
  localparam int BIT_INDEX_ZERO_IRQ_ENABLE   = 15;
  localparam int BIT_IWA     = 14;
  localparam int BIT_BROADCAST_IRQ_ENABLE    = 13;
  localparam int BIT_BUSY    = 12;
  localparam int BIT_ACC     = 11;
  localparam int BIT_PTRB    = 10;
  localparam int BIT_BROADCAST_SEEN_FLAG   = 9;
  localparam int BIT_ACK     = 8;
  localparam int BIT_STOP    = 3;
  localparam int BIT_PPSEL   = 2;
  localparam logic [15:0] CW_RESET = 16'h0000;
  // host may write these anytime; ppsel only while not executing
  localparam logic [15:0] CW_HOST_MASK = 16'hf008;
  // config register fields
  localparam int CFG_EXEC    = 0;
  localparam int CFG_BCINV   = 1;
  // irq enable / status fields
  localparam int IRQ_INDEX_ZERO_IRQ_ENABLE   = 0;
  localparam int IRQ_IWA     = 1;
  localparam int IRQ_BROADCAST_IRQ_ENABLE    = 2;
  // command decode
  localparam logic [4:0] SA_MODE_LO  = 5'h00;
  localparam logic [4:0] SA_MODE_HI  = 5'h1f;
  localparam logic [4:0] RT_BROADCAST_SEEN_FLAG    = 5'h1f;
  localparam logic [4:0] MC_TERM_RST = 5'h08;
  localparam logic [4:0] MC_DATA_LO  = 5'h10;
endpackage : mcw_pkg

// >>> mcw_ctrl.sv
/*
 * mcw_ctrl: receive and transmit mode code control words with APB access.
 * Assumes the terminal's command engine drives one-cycle start/done pulses
 * with the command fields held stable from start to done.
 */
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Transmit mode control word used for T/R one and subaddress 0 or 31.
// - Receive mode control word used for T/R zero and subaddress 0 or 31.
// - Bits 11..8 device-only; bit 2 host-written while not executing; 3, 15..12 anytime.
// - Master reset clears all; software reset clears accessed, pointer-B, broadcast.
// - Accessed flag set on completion, cleared by a host read.
// - Valid broadcast receive mode command sets receive broadcast flag.
// - Valid broadcast transmit mode command sets transmit broadcast flag.
// - Broadcast-invalid option rejects address 31 commands entirely.
// - Bit 2 high selects ping-pong, low selects indexed buffering.
// - Stop request clears acknowledge; removing it sets acknowledge again.
// - Receive, ping-pong, acknowledge low: overwrite chosen buffer, no toggle.
// - Transmit, ping-pong, acknowledge low: single buffer per pointer-B, no toggle.
// - Pointer-B selects A or B; toggles after each error-free message.
// - No toggle after error, illegal or busy; resets clear pointer-B.
// - Index-zero interrupt when both enables set and index hits 1 to 0.
// - Accessed interrupt on each valid command when both enables set.
// - Broadcast interrupt after valid broadcast command when both enables set.
// - Force busy answers busy, moves no data for codes 16-31, no toggle.
// - Force busy ignored for terminal reset mode code 8.
// - Unused bits 7..4 and 1..0 carry no function; they read zero.
module mcw_ctrl #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  input  wire logic              i_software_reset,
  // apb slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // command engine
  input  wire logic              i_cmd_start,
  input  wire logic              i_cmd_done,
  input  wire logic              i_cmd_error,
  input  wire logic              i_cmd_illegal,
  input  wire logic              i_cmd_tx,
  input  wire logic [4:0]        i_cmd_rt_addr,
  input  wire logic [4:0]        i_cmd_subaddr,
  input  wire logic [4:0]        i_cmd_mode_code,
  input  wire logic              i_index_hit_zero,
  // decisions back to the command engine
  output logic                   o_cmd_is_mode,
  output logic                   o_cmd_valid,
  output logic                   o_respond_busy,
  output logic                   o_data_inhibit,
  output logic                   o_use_pingpong,
  output logic                   o_use_pointer_b,
  output logic                   o_message_irq_out
);

  // command decode
  wire        sa_mode   = (i_cmd_subaddr == mcw_pkg::SA_MODE_LO) ||
                          (i_cmd_subaddr == mcw_pkg::SA_MODE_HI);
  wire        is_broadcast_seen_flag  = (i_cmd_rt_addr == mcw_pkg::RT_BROADCAST_SEEN_FLAG);
  logic [15:0] rx_reg, tx_reg;
  logic [2:0]  cfg_reg;
  logic [2:0]  irq_en_reg;
  logic [2:0]  irq_stat_reg;
  logic        busy_reg;
  wire        bc_inv    = cfg_reg[mcw_pkg::CFG_BCINV];
  wire        executing = cfg_reg[mcw_pkg::CFG_EXEC];
  wire        mode_cmd  = sa_mode;
  wire        cmd_ok    = mode_cmd && !(is_broadcast_seen_flag && bc_inv);
  wire [15:0] cur_cw    = i_cmd_tx ? tx_reg : rx_reg;
  wire        term_rst  = (i_cmd_mode_code == mcw_pkg::MC_TERM_RST);
  wire        busy      = cur_cw[mcw_pkg::BIT_BUSY] && !term_rst;
  wire        data_code = (i_cmd_mode_code >= mcw_pkg::MC_DATA_LO);
  wire        pp_sel    = cur_cw[mcw_pkg::BIT_PPSEL];
  wire        pp_live   = pp_sel && cur_cw[mcw_pkg::BIT_ACK];
  wire        good_done = i_cmd_done && cmd_ok && !i_cmd_error && !i_cmd_illegal;
  wire        toggle    = good_done && pp_live && !busy;

  assign o_cmd_is_mode   = mode_cmd;
  assign o_cmd_valid     = cmd_ok;
  assign o_respond_busy  = cmd_ok && busy;
  assign o_data_inhibit  = cmd_ok && busy && data_code;
  assign o_use_pingpong  = pp_sel;
  assign o_use_pointer_b = pp_sel && cur_cw[mcw_pkg::BIT_PTRB];

  // command in progress, gates acknowledge updates
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      busy_reg <= 1'b0;
    end else if (i_cmd_start) begin
      busy_reg <= 1'b1;
    end else if (i_cmd_done) begin
      busy_reg <= 1'b0;
    end
  end
  wire idle = !busy_reg && !i_cmd_start;

  // apb decode
  wire        apb_acc = i_psel && i_penable;
  wire        apb_wr  = apb_acc && i_pwrite;
  wire        apb_rd  = apb_acc && !i_pwrite;
  wire        hit_rx  = (i_paddr == mcw_pkg::ADDR_RX_CTRL);
  wire        hit_tx  = (i_paddr == mcw_pkg::ADDR_TX_CTRL);
  wire        hit_cfg = (i_paddr == mcw_pkg::ADDR_CONFIG);
  wire        hit_ien = (i_paddr == mcw_pkg::ADDR_IRQ_EN);
  wire        hit_ist = (i_paddr == mcw_pkg::ADDR_IRQ_STAT);
  wire        mapped  = hit_rx || hit_tx || hit_cfg || hit_ien || hit_ist;
  assign o_pready  = 1'b1;
  assign o_pslverr = apb_acc && !mapped;

  // host write mask: ppsel only while not executing
  wire [15:0] wmask = mcw_pkg::CW_HOST_MASK |
                      (executing ? 16'h0000 : (16'h0001 << mcw_pkg::BIT_PPSEL));

  // per-word next-state, one generate entry per direction
  logic [15:0] cw_next [2];
  logic [2:0]  irq_ev  [2];
  genvar g;
  for (g = 0; g < 2; g++) begin : g_cw
    wire [15:0] cw     = (g == 1) ? tx_reg : rx_reg;
    wire        sel    = (i_cmd_tx == (g == 1)) && cmd_ok;
    wire        host_w = apb_wr && ((g == 1) ? hit_tx : hit_rx);
    wire        host_r = apb_rd && ((g == 1) ? hit_tx : hit_rx);
    wire        done   = i_cmd_done && sel;
    wire        okdone = good_done && sel;
    always_comb begin
      cw_next[g] = cw;
      irq_ev[g]  = 3'b000;
      if (host_w) begin
        cw_next[g] = (cw & ~wmask) | (i_pwdata[15:0] & wmask);
      end
      if (idle && executing) begin
        cw_next[g][mcw_pkg::BIT_ACK] = cw[mcw_pkg::BIT_PPSEL] && !cw[mcw_pkg::BIT_STOP];
      end
      if (host_r) begin
        cw_next[g][mcw_pkg::BIT_ACC] = 1'b0;
      end
      if (done) begin
        cw_next[g][mcw_pkg::BIT_ACC] = 1'b1;
      end
      if (okdone && is_broadcast_seen_flag) begin
        cw_next[g][mcw_pkg::BIT_BROADCAST_SEEN_FLAG] = 1'b1;
      end
      if (toggle && sel) begin
        cw_next[g][mcw_pkg::BIT_PTRB] = !cw[mcw_pkg::BIT_PTRB];
      end
      if (i_software_reset) begin
        cw_next[g][mcw_pkg::BIT_ACC]   = 1'b0;
        cw_next[g][mcw_pkg::BIT_PTRB]  = 1'b0;
        cw_next[g][mcw_pkg::BIT_BROADCAST_SEEN_FLAG] = 1'b0;
      end
      irq_ev[g][mcw_pkg::IRQ_INDEX_ZERO_IRQ_ENABLE] = okdone && !cw[mcw_pkg::BIT_PPSEL] &&
                                      i_index_hit_zero && cw[mcw_pkg::BIT_INDEX_ZERO_IRQ_ENABLE];
      irq_ev[g][mcw_pkg::IRQ_IWA]   = okdone && cw[mcw_pkg::BIT_IWA];
      irq_ev[g][mcw_pkg::IRQ_BROADCAST_IRQ_ENABLE]  = okdone && is_broadcast_seen_flag && cw[mcw_pkg::BIT_BROADCAST_IRQ_ENABLE];
    end
  end

  wire [2:0] irq_set = (irq_ev[0] | irq_ev[1]) & irq_en_reg;
  wire [2:0] irq_clr = (apb_wr && hit_ist) ? i_pwdata[2:0] : 3'b000;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rx_reg       <= mcw_pkg::CW_RESET;
      tx_reg       <= mcw_pkg::CW_RESET;
      cfg_reg      <= '0;
      irq_en_reg   <= '0;
      irq_stat_reg <= '0;
    end else begin
      rx_reg       <= cw_next[0];
      tx_reg       <= cw_next[1];
      if (apb_wr && hit_cfg) cfg_reg <= i_pwdata[2:0];
      if (apb_wr && hit_ien) irq_en_reg <= i_pwdata[2:0];
      // set wins over write-one-to-clear
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
    end
  end

  // read data: unused control word bits read zero
  wire [15:0] cw_rd_mask = 16'hff0c;
  wire [31:0] rd_mux =
      hit_rx  ? {16'h0000, rx_reg & cw_rd_mask} :
      hit_tx  ? {16'h0000, tx_reg & cw_rd_mask} :
      hit_cfg ? {29'h0, cfg_reg} :
      hit_ien ? {29'h0, irq_en_reg} :
      hit_ist ? {29'h0, irq_stat_reg} : 32'h0000_0000;
  assign o_prdata          = apb_rd ? rd_mux : 32'h0000_0000;
  assign o_message_irq_out = |irq_stat_reg;

  // broadcast flag never set while broadcast is invalid
  broadcast_seen_flag_inv_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_cmd_done && is_broadcast_seen_flag && bc_inv) |=> !$rose(rx_reg[mcw_pkg::BIT_BROADCAST_SEEN_FLAG]) &&
                                         !$rose(tx_reg[mcw_pkg::BIT_BROADCAST_SEEN_FLAG]))
    else $error("broadcast flag set while broadcast invalid");
  accessed_set_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_cmd_done && cmd_ok && !i_cmd_tx && !i_software_reset) |=> rx_reg[mcw_pkg::BIT_ACC])
    else $error("accessed flag not set after message");
  read_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (apb_rd && hit_tx && !(i_cmd_done && cmd_ok && i_cmd_tx)) |=> !tx_reg[mcw_pkg::BIT_ACC])
    else $error("accessed flag not cleared by read");
  busy_toggle_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_cmd_done && busy && !apb_wr && !i_software_reset) |=>
      $stable(rx_reg[mcw_pkg::BIT_PTRB]) && $stable(tx_reg[mcw_pkg::BIT_PTRB]))
    else $error("pointer toggled under busy");
  mc8_busy_a: assert property (@(posedge i_clk) disable iff (i_reset)
    term_rst |-> !o_respond_busy)
    else $error("busy answered for terminal reset");
  sequence stop_raised_s;
    executing && idle && rx_reg[mcw_pkg::BIT_STOP];
  endsequence
  ack_stop_a: assert property (@(posedge i_clk) disable iff (i_reset)
    stop_raised_s |=> !rx_reg[mcw_pkg::BIT_ACK])
    else $error("acknowledge not cleared on stop request");
  ack_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (busy_reg && !i_cmd_start) |=> $stable(rx_reg[mcw_pkg::BIT_ACK]))
    else $error("acknowledge moved during a command");
  ptrb_flip_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (toggle && !i_cmd_tx && !i_software_reset) |=>
      rx_reg[mcw_pkg::BIT_PTRB] != $past(rx_reg[mcw_pkg::BIT_PTRB]))
    else $error("pointer-B did not toggle");
  soft_rst_a: assert property (@(posedge i_clk) disable iff (i_reset)
    i_software_reset |=> tx_reg[11:9] == 3'b000 && rx_reg[11:9] == 3'b000)
    else $error("software reset left status bits");

  // decode and selection checks
  // transmit word steers transmit mode commands
  tx_select_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_cmd_tx && o_cmd_valid) |-> o_use_pingpong == tx_reg[mcw_pkg::BIT_PPSEL])
    else $error("transmit word not selected");

  // receive word steers receive mode commands
  rx_select_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (!i_cmd_tx && o_cmd_valid) |-> o_use_pingpong == rx_reg[mcw_pkg::BIT_PPSEL])
    else $error("receive word not selected");

  // status bits never follow a host write
  host_lock_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (apb_wr && hit_tx && !i_cmd_done && !i_software_reset) |=> $stable(tx_reg[11:9]))
    else $error("host wrote device status bits");

  // buffer mode frozen while executing
  ppsel_lock_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (apb_wr && hit_tx && executing) |=> $stable(tx_reg[mcw_pkg::BIT_PPSEL]))
    else $error("buffer mode changed while executing");

  // master reset clears both words
  master_rst_a: assert property (@(posedge i_clk)
    i_reset |=> rx_reg == mcw_pkg::CW_RESET && tx_reg == mcw_pkg::CW_RESET)
    else $error("master reset left control word bits");

  // software reset keeps host fields
  soft_keep_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_software_reset && !apb_wr) |=> $stable(tx_reg[15:12]) && $stable(rx_reg[15:12]))
    else $error("software reset changed host bits");

  // completion marks the transmit word accessed
  acc_tx_set_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_cmd_done && cmd_ok && i_cmd_tx && !i_software_reset) |=> tx_reg[mcw_pkg::BIT_ACC])
    else $error("transmit accessed flag not set");

  // host read clears receive accessed flag
  rd_clr_rx_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (apb_rd && hit_rx && !(i_cmd_done && cmd_ok && !i_cmd_tx)) |=> !rx_reg[mcw_pkg::BIT_ACC])
    else $error("receive accessed flag not cleared");

  // receive broadcast flag
  broadcast_seen_flag_rx_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (good_done && is_broadcast_seen_flag && !i_cmd_tx && !i_software_reset) |=> rx_reg[mcw_pkg::BIT_BROADCAST_SEEN_FLAG])
    else $error("receive broadcast flag not set");

  // transmit broadcast flag
  broadcast_seen_flag_tx_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (good_done && is_broadcast_seen_flag && i_cmd_tx && !i_software_reset) |=> tx_reg[mcw_pkg::BIT_BROADCAST_SEEN_FLAG])
    else $error("transmit broadcast flag not set");

  // address 31 refused while broadcast is invalid
  broadcast_seen_flag_reject_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (is_broadcast_seen_flag && bc_inv) |-> !o_cmd_valid)
    else $error("broadcast accepted while invalid");

  // pointer-B only meaningful in ping-pong
  pp_out_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !o_use_pingpong |-> !o_use_pointer_b)
    else $error("pointer-B used outside ping-pong");

  // stop cleared by host while idle: acknowledge returns
  sequence stop_cleared_s;
    executing && idle && tx_reg[mcw_pkg::BIT_PPSEL] && !tx_reg[mcw_pkg::BIT_STOP];
  endsequence
  ack_return_a: assert property (@(posedge i_clk) disable iff (i_reset)
    stop_cleared_s |=> tx_reg[mcw_pkg::BIT_ACK])
    else $error("acknowledge not restored");

  // stop request drops transmit acknowledge
  ack_tx_stop_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (executing && idle && tx_reg[mcw_pkg::BIT_STOP]) |=> !tx_reg[mcw_pkg::BIT_ACK])
    else $error("transmit acknowledge not cleared");

  // suspended receive ping-pong keeps its buffer
  rx_ptr_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_cmd_done && !i_cmd_tx && rx_reg[mcw_pkg::BIT_PPSEL] && !rx_reg[mcw_pkg::BIT_ACK] &&
     !i_software_reset) |=> $stable(rx_reg[mcw_pkg::BIT_PTRB]))
    else $error("receive pointer toggled while suspended");

  // suspended transmit ping-pong keeps its buffer
  tx_ptr_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_cmd_done && i_cmd_tx && tx_reg[mcw_pkg::BIT_PPSEL] && !tx_reg[mcw_pkg::BIT_ACK] &&
     !i_software_reset) |=> $stable(tx_reg[mcw_pkg::BIT_PTRB]))
    else $error("transmit pointer toggled while suspended");

  // buffer choice follows pointer-B
  ptr_out_a: assert property (@(posedge i_clk) disable iff (i_reset)
    o_use_pingpong |-> o_use_pointer_b == cur_cw[mcw_pkg::BIT_PTRB])
    else $error("pointer-B output wrong");

  // failed messages leave pointer-B alone
  err_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_cmd_done && (i_cmd_error || i_cmd_illegal) && !i_software_reset) |=>
      $stable(tx_reg[mcw_pkg::BIT_PTRB]) && $stable(rx_reg[mcw_pkg::BIT_PTRB]))
    else $error("pointer-B toggled after failed message");

  // index reaching zero raises its interrupt
  index_zero_irq_enable_irq_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (good_done && i_cmd_tx && !tx_reg[mcw_pkg::BIT_PPSEL] && i_index_hit_zero &&
     tx_reg[mcw_pkg::BIT_INDEX_ZERO_IRQ_ENABLE] && irq_en_reg[mcw_pkg::IRQ_INDEX_ZERO_IRQ_ENABLE]) |=>
      irq_stat_reg[mcw_pkg::IRQ_INDEX_ZERO_IRQ_ENABLE] && o_message_irq_out)
    else $error("index-zero interrupt missing");

  // accessed interrupt on each valid completion
  iwa_irq_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (good_done && cur_cw[mcw_pkg::BIT_IWA] && irq_en_reg[mcw_pkg::IRQ_IWA]) |=>
      irq_stat_reg[mcw_pkg::IRQ_IWA])
    else $error("accessed interrupt missing");

  // broadcast interrupt
  broadcast_irq_enable_irq_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (good_done && is_broadcast_seen_flag && cur_cw[mcw_pkg::BIT_BROADCAST_IRQ_ENABLE] && irq_en_reg[mcw_pkg::IRQ_BROADCAST_IRQ_ENABLE]) |=>
      irq_stat_reg[mcw_pkg::IRQ_BROADCAST_IRQ_ENABLE])
    else $error("broadcast interrupt missing");

  // data inhibited only for busy data-bearing codes
  inhibit_a: assert property (@(posedge i_clk) disable iff (i_reset)
    o_data_inhibit |-> o_respond_busy && (i_cmd_mode_code >= mcw_pkg::MC_DATA_LO))
    else $error("data inhibit without busy data code");

  // forced busy is answered
  busy_answer_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (o_cmd_valid && cur_cw[mcw_pkg::BIT_BUSY] && !term_rst) |-> o_respond_busy)
    else $error("forced busy not answered");

  // unused bits read zero
  unused_zero_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (apb_rd && hit_rx) |-> o_prdata[7:4] == 4'h0 && o_prdata[1:0] == 2'h0)
    else $error("unused control bits read nonzero");

  // transmit acknowledge frozen during a command
  ack_tx_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (busy_reg && !i_cmd_start) |=> $stable(tx_reg[mcw_pkg::BIT_ACK]))
    else $error("transmit acknowledge moved during a command");

endmodule : mcw_ctrl

`default_nettype wire

// >>> mcw_cmd_model.sv
/*
 * mcw_cmd_model: command engine stand-in that drives start/done pulses.
 * Assumes the bench calls its tasks in the i_clk domain.
 */
`timescale 1ns/1ps
`default_nettype none
module mcw_cmd_model (
  // clock
  input  wire logic  i_clk,
  // command towards the block
  output logic       o_start,
  output logic       o_done,
  output logic       o_error,
  output logic       o_tx,
  output logic [4:0] o_rt,
  output logic [4:0] o_sa,
  output logic [4:0] o_mc
);
  initial begin
    {o_start, o_done, o_error} = 3'b000;
    {o_tx, o_rt, o_sa, o_mc} = 16'h5555;
  end
  task automatic begin_cmd(input logic tx, input logic [4:0] rt, sa, mc);
    @(posedge i_clk);
    {o_tx, o_rt, o_sa, o_mc, o_start} <= {tx, rt, sa, mc, 1'b1};
    @(posedge i_clk);
    o_start <= 1'b0;
  endtask : begin_cmd
  task automatic end_cmd(input logic err);
    @(posedge i_clk);
    {o_done, o_error} <= {1'b1, err};
    @(posedge i_clk);
    {o_done, o_error} <= 2'b00;
    // released fields must not keep showing the last command
    {o_tx, o_rt, o_sa, o_mc} <= ~{o_tx, o_rt, o_sa, o_mc};
  endtask : end_cmd
endmodule : mcw_cmd_model
`default_nettype wire

// >>> mcw_ctrl_tb.sv
/*
 * mcw_ctrl_tb: self-checking bench for the mode code control words.
 * Assumes a zero-wait APB slave and mcw_cmd_model as command engine.
 */
`timescale 1ns/1ps
`default_nettype none
module mcw_ctrl_tb;
  localparam logic [7:0] RXA = mcw_pkg::ADDR_RX_CTRL;
  localparam logic [7:0] TXA = mcw_pkg::ADDR_TX_CTRL;
  localparam logic [7:0] CFA = mcw_pkg::ADDR_CONFIG;
  localparam logic [7:0] IEA = mcw_pkg::ADDR_IRQ_EN;
  localparam logic [7:0] ISA = mcw_pkg::ADDR_IRQ_STAT;
  logic        i_clk = 1'b0;
  logic        rst   = 1'b1;
  logic        software_reset  = 1'b0;
  logic        psel  = 1'b0;
  logic        pen   = 1'b0;
  logic        pwr   = 1'b0;
  logic [7:0]  pa    = 8'h00;
  logic [31:0] pwd   = 32'h0;
  logic [31:0] prd, r;
  logic        prdy, perr, e, st, dn, er, tx, is_m, vld, busy, inh, upp, upb, irq;
  logic [4:0]  rt, sa, mc;
  logic        ill   = 1'b0;
  logic        hz    = 1'b0;
  int          fails = 0;
  int          n_compared = 0;
  int          cyc = 0;
  always #10 i_clk = ~i_clk;
  mcw_cmd_model i_mcw_cmd_model (.i_clk(i_clk), .o_start(st), .o_done(dn),
    .o_error(er), .o_tx(tx), .o_rt(rt), .o_sa(sa), .o_mc(mc));
  mcw_ctrl i_mcw_ctrl (.i_clk(i_clk), .i_reset(rst), .i_software_reset(software_reset),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
    .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr), .i_cmd_start(st),
    .i_cmd_done(dn), .i_cmd_error(er), .i_cmd_illegal(ill), .i_cmd_tx(tx),
    .i_cmd_rt_addr(rt), .i_cmd_subaddr(sa), .i_cmd_mode_code(mc),
    .i_index_hit_zero(hz), .o_cmd_is_mode(is_m), .o_cmd_valid(vld),
    .o_respond_busy(busy), .o_data_inhibit(inh), .o_use_pingpong(upp),
    .o_use_pointer_b(upb), .o_message_irq_out(irq));
  task automatic conclude();
    $display("compared=%0d mismatches=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      conclude();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    {psel, pen, pwr, pa, pwd} <= {2'b10, w, a, d};
    @(posedge i_clk);
    pen <= 1'b1;
    @(posedge i_clk);
    while (prdy !== 1'b1) @(posedge i_clk);
    {e, r} = {perr, prd};
    {psel, pen} <= 2'b00;
  endtask : apb
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0, d});
  endtask : wr
  task automatic cmd(input logic t, input logic [4:0] a, s, m, input logic err);
    i_mcw_cmd_model.begin_cmd(t, a, s, m);
    i_mcw_cmd_model.end_cmd(err);
  endtask : cmd
  task automatic t_reset();
    rd(RXA, 32'h0);
    rd(TXA, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_host();
    wr(TXA, 16'hffff);
    rd(TXA, 32'hf00c);
    wr(CFA, 16'h0001);
    wr(TXA, 16'h0000);
    rd(TXA, 32'h0104);
    wr(RXA, 16'h0004);
    rd(RXA, 32'h0000);
    $display("test host access done");
  endtask : t_host
  task automatic t_pingpong();
    i_mcw_cmd_model.begin_cmd(1'b1, 5'd5, 5'd0, 5'd2);
    chk({upp, upb, is_m, vld}, 4'b1011);
    i_mcw_cmd_model.end_cmd(1'b0);
    rd(TXA, 32'h0d04);
    rd(TXA, 32'h0504);
    cmd(1'b1, 5'd5, 5'd31, 5'd3, 1'b1);
    rd(TXA, 32'h0d04);
    i_mcw_cmd_model.begin_cmd(1'b1, 5'd5, 5'd0, 5'd2);
    chk({upp, upb}, 2'b11);
    wr(TXA, 16'h0008);
    rd(TXA, 32'h050c);
    i_mcw_cmd_model.end_cmd(1'b0);
    rd(TXA, 32'h080c);
    cmd(1'b1, 5'd5, 5'd0, 5'd2, 1'b0);
    rd(TXA, 32'h080c);
    wr(TXA, 16'h1000);
    $display("test ping-pong done");
  endtask : t_pingpong
  task automatic t_busy();
    i_mcw_cmd_model.begin_cmd(1'b1, 5'd5, 5'd0, 5'd17);
    chk({busy, inh}, 2'b11);
    i_mcw_cmd_model.end_cmd(1'b0);
    rd(TXA, 32'h1904);
    i_mcw_cmd_model.begin_cmd(1'b1, 5'd5, 5'd0, 5'd8);
    chk({busy, inh}, 2'b00);
    i_mcw_cmd_model.end_cmd(1'b1);
    $display("test busy done");
  endtask : t_busy
  task automatic t_broadcast_seen_flag();
    cmd(1'b0, 5'd31, 5'd31, 5'd1, 1'b0);
    cmd(1'b1, 5'd31, 5'd0, 5'd1, 1'b0);
    rd(RXA, 32'h0a00);
    rd(TXA, 32'h1b04);
    @(posedge i_clk);
    software_reset <= 1'b1;
    @(posedge i_clk);
    software_reset <= 1'b0;
    rd(RXA, 32'h0);
    rd(TXA, 32'h1104);
    @(posedge i_clk);
    rst <= 1'b1;
    @(posedge i_clk);
    rst <= 1'b0;
    rd(RXA, 32'h0);
    rd(TXA, 32'h0);
    wr(CFA, 16'h0003);
    i_mcw_cmd_model.begin_cmd(1'b0, 5'd31, 5'd31, 5'd1);
    chk(vld, 1'b0);
    i_mcw_cmd_model.end_cmd(1'b0);
    apb(1'b0, RXA, 32'h0);
    chk(r & 32'h0200, 32'h0);
    wr(CFA, 16'h0001);
    $display("test broadcast done");
  endtask : t_broadcast_seen_flag
  task automatic t_irq();
    wr(IEA, 16'h0002);
    wr(TXA, 16'h4000);
    cmd(1'b1, 5'd5, 5'd0, 5'd2, 1'b0);
    @(posedge i_clk);
    chk(irq, 1'b1);
    rd(ISA, 32'h2);
    wr(ISA, 16'h0002);
    @(posedge i_clk);
    chk(irq, 1'b0);
    ill <= 1'b1;
    cmd(1'b1, 5'd5, 5'd0, 5'd2, 1'b0);
    ill <= 1'b0;
    @(posedge i_clk);
    chk(irq, 1'b0);
    wr(IEA, 16'h0001);
    wr(TXA, 16'h8000);
    hz <= 1'b1;
    cmd(1'b1, 5'd5, 5'd0, 5'd2, 1'b0);
    hz <= 1'b0;
    rd(ISA, 32'h1);
    wr(ISA, 16'h0001);
    wr(IEA, 16'h0004);
    wr(TXA, 16'h2000);
    cmd(1'b1, 5'd31, 5'd0, 5'd1, 1'b0);
    rd(ISA, 32'h4);
    $display("test interrupts done");
  endtask : t_irq
  initial begin
    repeat (20) @(posedge i_clk);
    rst <= 1'b0;
    t_reset();
    t_host();
    t_pingpong();
    t_busy();
    t_broadcast_seen_flag();
    t_irq();
    conclude();
  end
endmodule : mcw_ctrl_tb
`default_nettype wire
